// ===== rtl/dmct_pkg.sv
// constants for the dual mode compare timer
package dmct_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [15:0] DMCT_IDX_CTRL = 16'hffb6;
  localparam logic [15:0] DMCT_IDX_STATUS = 16'hffb7;
  localparam logic [15:0] DMCT_IDX_CNT_HIGH = 16'hffb8;
  localparam logic [15:0] DMCT_IDX_CNT_LOW = 16'hffb9;
  localparam logic [15:0] DMCT_IDX_CMP_HIGH = 16'hffba;
  localparam logic [15:0] DMCT_IDX_CMP_LOW = 16'hffbb;
  localparam logic [15:0] DMCT_IDX_CLK_STOP = 16'hfffa;
  localparam int DMCT_ADDR_W = 18;

  // control word fields
  localparam int DMCT_CTRL_HIGH_LEVEL = 7;
  localparam int DMCT_CTRL_HIGH_SEL_MSB = 6;
  localparam int DMCT_CTRL_HIGH_SEL_LSB = 4;
  localparam int DMCT_CTRL_LOW_LEVEL = 3;
  localparam int DMCT_CTRL_LOW_SEL_MSB = 2;
  localparam int DMCT_CTRL_LOW_SEL_LSB = 0;

  // status word fields
  localparam int DMCT_ST_HIGH_OVF = 7;
  localparam int DMCT_ST_HIGH_MATCH = 6;
  localparam int DMCT_ST_HIGH_OVF_IE = 5;
  localparam int DMCT_ST_HIGH_CLR = 4;
  localparam int DMCT_ST_LOW_OVF = 3;
  localparam int DMCT_ST_LOW_MATCH = 2;
  localparam int DMCT_ST_LOW_OVF_IE = 1;
  localparam int DMCT_ST_LOW_CLR = 0;
  localparam logic [7:0] DMCT_ST_FLAG_MASK = 8'hcc;

  // clock stop register: this bit low holds the timer in standby
  localparam int DMCT_CLKSTOP_RUN = 2;

  // reset values and counter maximum
  localparam logic [7:0] DMCT_CTRL_RST = 8'h00;
  localparam logic [7:0] DMCT_STATUS_RST = 8'h00;
  localparam logic [7:0] DMCT_CNT_RST = 8'h00;
  localparam logic [7:0] DMCT_CMP_RST = 8'hff;
  localparam logic [7:0] DMCT_CLKSTOP_RST = 8'hff;
  localparam logic [7:0] DMCT_CNT_MAX = 8'hff;

  // prescaler taps
  localparam logic [4:0] DMCT_DIV32_TAP = 5'h1f;
  localparam logic [4:0] DMCT_DIV16_TAP = 5'h0f;
  localparam logic [4:0] DMCT_DIV4_TAP = 5'h03;
  localparam logic [1:0] DMCT_SUB_DIV4_TAP = 2'h3;

  // clock select codes
  localparam logic [2:0] DMCT_SEL_DIV32 = 3'h4;
  localparam logic [2:0] DMCT_SEL_DIV16 = 3'h5;
  localparam logic [2:0] DMCT_SEL_DIV4 = 3'h6;
  localparam logic [2:0] DMCT_SEL_SUB4 = 3'h7;

endpackage : dmct_pkg

// ===== rtl/dmct_timer.sv
// dual mode compare timer with avalon-mm register slave
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module dmct_timer
  import dmct_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic [DMCT_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_subclock,
  input wire logic i_event_input_pin,
  input wire logic i_event_edge_rising,
  output logic o_high_toggle_pin,
  output logic o_low_toggle_pin,
  output logic o_high_request_set,
  output logic o_low_request_set
);

  function automatic logic reg_hit(input logic en, input logic [DMCT_ADDR_W-1:0] addr,
                                   input logic [15:0] idx);
    reg_hit = en && (addr[1:0] == 2'h0) && (addr[DMCT_ADDR_W-1:2] == idx);
  endfunction : reg_hit

  // alt is the event edge for the low half, tied to zero for the high half
  function automatic logic src_tick(input logic [2:0] sel, input logic alt, input logic t32,
                                    input logic t16, input logic t4, input logic tw);
    logic r;
    r = 1'b0;
    unique case (sel)
      DMCT_SEL_DIV32: r = t32;
      DMCT_SEL_DIV16: r = t16;
      DMCT_SEL_DIV4: r = t4;
      DMCT_SEL_SUB4: r = tw;
      default: r = alt;
    endcase
    src_tick = r;
  endfunction : src_tick

  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic bus_req, bus_first, bus_accept;
  logic rd_en, wr_en;
  logic [7:0] wdata;
  logic [7:0] read_mux;

  logic [4:0] div_q, div_d;
  logic sub_prev_q, sub_prev_d;
  logic [1:0] sub_div_q, sub_div_d;
  logic evt_prev_q, evt_prev_d;
  logic tick32, tick16, tick4, tick_sub, tick_evt;

  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] status_q, status_d;
  logic [7:0] armed_q, armed_d;
  logic [7:0] cnt_h_q, cnt_h_d;
  logic [7:0] cnt_l_q, cnt_l_d;
  logic [7:0] cmp_h_q, cmp_h_d;
  logic [7:0] cmp_l_q, cmp_l_d;
  logic [7:0] clkstop_q, clkstop_d;
  logic [7:0] temp_q, temp_d;
  logic tog_h_q, tog_h_d;
  logic tog_l_q, tog_l_d;
  logic req_h_q, req_h_d;
  logic req_l_q, req_l_d;

  logic mode8, run;
  logic tick_l, tick_h;
  logic [15:0] cnt16, cmp16, cnt16_next;
  logic match16, ovf16;
  logic match_h, match_l, ovf_h, ovf_l;
  logic match_h_evt, match_l_evt, ovf_h_evt, ovf_l_evt;
  logic [7:0] flag_set, flag_clr;
  logic wr_ctrl, wr_status, wr_cnt_h, wr_cnt_l, wr_cmp_h, wr_cmp_l, wr_clkstop;
  logic rd_status, rd_cnt_h, rd_cmp_h;

  // bus slave: one wait cycle, read data snapshot on the first edge
  always_comb
  begin
    bus_req = i_avs_read || i_avs_write;
    bus_first = bus_req && wait_q;
    bus_accept = bus_req && !wait_q;
    rd_en = bus_first && i_avs_read;
    wr_en = bus_accept && i_avs_write && i_avs_byteenable[0];
    wdata = i_avs_writedata[7:0];
    wait_d = !bus_first;
    rdata_d = rd_en ? {24'h000000, read_mux} : rdata_q;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // prescaler, subclock divider and event edge detect
  always_comb
  begin
    div_d = div_q + 5'h01;
    sub_prev_d = i_subclock;
    evt_prev_d = i_event_input_pin;
    tick32 = (div_q == DMCT_DIV32_TAP);
    tick16 = ((div_q & DMCT_DIV16_TAP) == DMCT_DIV16_TAP);
    tick4 = ((div_q & DMCT_DIV4_TAP) == DMCT_DIV4_TAP);
    tick_sub = 1'b0;
    sub_div_d = sub_div_q;
    if (i_subclock && !sub_prev_q)
    begin
      sub_div_d = sub_div_q + 2'h1;
      tick_sub = (sub_div_q == DMCT_SUB_DIV4_TAP);
    end
    // edge polarity comes from the external edge select
    tick_evt = i_event_edge_rising ? (i_event_input_pin && !evt_prev_q)
                                   : (!i_event_input_pin && evt_prev_q);
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      div_q <= 5'h00;
      sub_prev_q <= 1'b0;
      sub_div_q <= 2'h0;
      evt_prev_q <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      sub_prev_q <= sub_prev_d;
      sub_div_q <= sub_div_d;
      evt_prev_q <= evt_prev_d;
    end
  end

  // register decode
  always_comb
  begin
    wr_ctrl = reg_hit(wr_en, i_avs_address, DMCT_IDX_CTRL);
    wr_status = reg_hit(wr_en, i_avs_address, DMCT_IDX_STATUS);
    wr_cnt_h = reg_hit(wr_en, i_avs_address, DMCT_IDX_CNT_HIGH);
    wr_cnt_l = reg_hit(wr_en, i_avs_address, DMCT_IDX_CNT_LOW);
    wr_cmp_h = reg_hit(wr_en, i_avs_address, DMCT_IDX_CMP_HIGH);
    wr_cmp_l = reg_hit(wr_en, i_avs_address, DMCT_IDX_CMP_LOW);
    wr_clkstop = reg_hit(wr_en, i_avs_address, DMCT_IDX_CLK_STOP);
    rd_status = reg_hit(rd_en, i_avs_address, DMCT_IDX_STATUS);
    rd_cnt_h = reg_hit(rd_en, i_avs_address, DMCT_IDX_CNT_HIGH);
    rd_cmp_h = reg_hit(rd_en, i_avs_address, DMCT_IDX_CMP_HIGH);
  end

  // counting, compare and flags
  always_comb
  begin
    mode8 = ctrl_q[DMCT_CTRL_HIGH_SEL_MSB];
    run = clkstop_q[DMCT_CLKSTOP_RUN];
    cnt16 = {cnt_h_q, cnt_l_q};
    cmp16 = {cmp_h_q, cmp_l_q};
    tick_l = run && src_tick(ctrl_q[DMCT_CTRL_LOW_SEL_MSB:DMCT_CTRL_LOW_SEL_LSB], tick_evt,
                             tick32, tick16, tick4, tick_sub);
    tick_h = run && mode8 && src_tick(ctrl_q[DMCT_CTRL_HIGH_SEL_MSB:DMCT_CTRL_HIGH_SEL_LSB],
                                      1'b0, tick32, tick16, tick4, tick_sub);
    match16 = !mode8 && tick_l && (cnt16 == cmp16);
    ovf16 = !mode8 && tick_l && (cnt16 == 16'hffff)
            && !(match16 && status_q[DMCT_ST_HIGH_CLR]);
    match_h = tick_h && (cnt_h_q == cmp_h_q);
    match_l = mode8 && tick_l && (cnt_l_q == cmp_l_q);
    ovf_h = tick_h && (cnt_h_q == DMCT_CNT_MAX) && !(match_h && status_q[DMCT_ST_HIGH_CLR]);
    ovf_l = mode8 && tick_l && (cnt_l_q == DMCT_CNT_MAX)
            && !(match_l && status_q[DMCT_ST_LOW_CLR]);
    match_h_evt = match16 || match_h;
    match_l_evt = match_l;
    ovf_h_evt = ovf16 || ovf_h;
    ovf_l_evt = ovf_l;

    cnt_h_d = cnt_h_q;
    cnt_l_d = cnt_l_q;
    if (!mode8)
    begin
      cnt16_next = cnt16;
      if (tick_l)
      begin
        // a match with clearing wins over the step
        cnt16_next = (match16 && status_q[DMCT_ST_HIGH_CLR]) ? 16'h0000
                     : 16'(cnt16 + 16'h0001);
      end
      cnt_h_d = cnt16_next[15:8];
      cnt_l_d = cnt16_next[7:0];
    end
    else
    begin
      cnt16_next = cnt16;
      cnt_h_d = !tick_h ? cnt_h_q : (match_h && status_q[DMCT_ST_HIGH_CLR]) ? DMCT_CNT_RST
                : 8'(cnt_h_q + 8'h01);
      cnt_l_d = !tick_l ? cnt_l_q : (match_l && status_q[DMCT_ST_LOW_CLR]) ? DMCT_CNT_RST
                : 8'(cnt_l_q + 8'h01);
    end

    cmp_h_d = cmp_h_q;
    cmp_l_d = cmp_l_q;
    temp_d = temp_q;
    // cpu writes override counting in the same cycle
    if (!mode8)
    begin
      temp_d = rd_cnt_h ? cnt_l_q : temp_d;
      temp_d = rd_cmp_h ? cmp_l_q : temp_d;
      temp_d = (wr_cnt_h || wr_cmp_h) ? wdata : temp_d;
      if (wr_cnt_l)
      begin
        cnt_h_d = temp_q;
        cnt_l_d = wdata;
      end
      if (wr_cmp_l)
      begin
        cmp_h_d = temp_q;
        cmp_l_d = wdata;
      end
    end
    else
    begin
      cnt_h_d = wr_cnt_h ? wdata : cnt_h_d;
      cnt_l_d = wr_cnt_l ? wdata : cnt_l_d;
      cmp_h_d = wr_cmp_h ? wdata : cmp_h_d;
      cmp_l_d = wr_cmp_l ? wdata : cmp_l_d;
    end

    ctrl_d = wr_ctrl ? wdata : ctrl_q;
    clkstop_d = wr_clkstop ? wdata : clkstop_q;

    flag_set = 8'h00;
    flag_set[DMCT_ST_HIGH_OVF] = ovf_h_evt;
    flag_set[DMCT_ST_HIGH_MATCH] = match_h_evt;
    flag_set[DMCT_ST_LOW_OVF] = ovf_l_evt;
    flag_set[DMCT_ST_LOW_MATCH] = match_l_evt;
    // only a flag seen as one can be cleared; writing one is ignored
    flag_clr = wr_status ? (armed_q & ~wdata & DMCT_ST_FLAG_MASK) : 8'h00;
    armed_d = rd_status ? (armed_q | (status_q & DMCT_ST_FLAG_MASK))
                        : (armed_q & ~flag_clr);
    // set wins over clear so no event is lost
    status_d = ((status_q & DMCT_ST_FLAG_MASK & ~flag_clr) | flag_set)
               | (wr_status ? (wdata & ~DMCT_ST_FLAG_MASK)
                            : (status_q & ~DMCT_ST_FLAG_MASK));

    req_h_d = (ovf_h_evt && status_q[DMCT_ST_HIGH_OVF_IE]) || match_h_evt;
    req_l_d = (ovf_l_evt && status_q[DMCT_ST_LOW_OVF_IE]) || match_l_evt;

    tog_h_d = match_h_evt ? !tog_h_q : tog_h_q;
    tog_l_d = match_l_evt ? !tog_l_q : tog_l_q;
    if (wr_ctrl)
    begin
      tog_h_d = wdata[DMCT_CTRL_HIGH_LEVEL];
      tog_l_d = wdata[DMCT_CTRL_LOW_LEVEL];
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      ctrl_q <= DMCT_CTRL_RST;
      status_q <= DMCT_STATUS_RST;
      armed_q <= 8'h00;
      cnt_h_q <= DMCT_CNT_RST;
      cnt_l_q <= DMCT_CNT_RST;
      cmp_h_q <= DMCT_CMP_RST;
      cmp_l_q <= DMCT_CMP_RST;
      clkstop_q <= DMCT_CLKSTOP_RST;
      temp_q <= 8'h00;
      tog_h_q <= 1'b0;
      tog_l_q <= 1'b0;
      req_h_q <= 1'b0;
      req_l_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      status_q <= status_d;
      armed_q <= armed_d;
      cnt_h_q <= cnt_h_d;
      cnt_l_q <= cnt_l_d;
      cmp_h_q <= cmp_h_d;
      cmp_l_q <= cmp_l_d;
      clkstop_q <= clkstop_d;
      temp_q <= temp_d;
      tog_h_q <= tog_h_d;
      tog_l_q <= tog_l_d;
      req_h_q <= req_h_d;
      req_l_q <= req_l_d;
    end
  end

  // control word reads as zero since it is write-only
  always_comb
  begin
    read_mux = 8'h00;
    if (i_avs_address[1:0] == 2'h0)
    begin
      unique case (i_avs_address[DMCT_ADDR_W-1:2])
        DMCT_IDX_STATUS: read_mux = status_q;
        DMCT_IDX_CNT_HIGH: read_mux = cnt_h_q;
        DMCT_IDX_CNT_LOW: read_mux = mode8 ? cnt_l_q : temp_q;
        DMCT_IDX_CMP_HIGH: read_mux = cmp_h_q;
        DMCT_IDX_CMP_LOW: read_mux = mode8 ? cmp_l_q : temp_q;
        DMCT_IDX_CLK_STOP: read_mux = clkstop_q;
        default: read_mux = 8'h00;
      endcase
    end
  end

  assign o_avs_readdata = rdata_q;
  assign o_avs_waitrequest = wait_q;
  assign o_high_toggle_pin = tog_h_q;
  assign o_low_toggle_pin = tog_l_q;
  assign o_high_request_set = req_h_q;
  assign o_low_request_set = req_l_q;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);

  logic no_wr;
  assign no_wr = !(bus_accept && i_avs_write);

  sequence s_wrap16;
    !mode8 && tick_l && (cnt16 == 16'hffff) && !status_q[DMCT_ST_HIGH_CLR] && no_wr;
  endsequence

  sequence s_match16;
    match16 && no_wr;
  endsequence

  chk_bus_answer: assert property (bus_first |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer not one wait cycle");
  chk_reset_counts: assert property ($past(i_reset) |-> cnt16 == 16'h0000)
    else $error("counter not zero after reset");
  chk_reset_compare: assert property ($past(i_reset) |-> cmp16 == 16'hffff)
    else $error("compare not all ones after reset");
  chk_reset_ctrl: assert property ($past(i_reset) |-> ctrl_q == 8'h00)
    else $error("control word not zero after reset");
  chk_wrap16_flag: assert property (s_wrap16 |=> status_q[7] && cnt16 == 16'h0000)
    else $error("16-bit wrap missed overflow flag");
  chk_clear16_match: assert property ((s_match16 and status_q[DMCT_ST_HIGH_CLR])
                                      |=> cnt16 == 16'h0000)
    else $error("16-bit match did not clear counter");
  chk_match16_req: assert property (s_match16 |=> status_q[6] && o_high_request_set)
    else $error("16-bit match missed flag or request");
  chk_toggle_high: assert property (match_h_evt && no_wr
                                    |=> o_high_toggle_pin != $past(o_high_toggle_pin))
    else $error("high pin did not toggle");
  chk_level_high: assert property (wr_ctrl |=> o_high_toggle_pin == $past(wdata[7]))
    else $error("high pin level not taken");
  chk_level_low: assert property (wr_ctrl |=> o_low_toggle_pin == $past(wdata[3]))
    else $error("low pin level not taken");
  chk_flag_source: assert property ($rose(status_q[7]) |-> $past(ovf_h_evt))
    else $error("overflow flag set without event");
  chk_temp_commit: assert property (!mode8 && wr_cnt_l |=> cnt_h_q == $past(temp_q))
    else $error("low write did not commit staged byte");
  chk_half_hold: assert property (mode8 && !tick_h && no_wr && $stable(mode8)
                                  |=> cnt_h_q == $past(cnt_h_q))
    else $error("high half moved without its tick");

endmodule : dmct_timer

// ===== testbench/dmct_req_bank.sv
// far side model: request flag bank fed by the timer's request pulses
`timescale 1ns/1ps
module dmct_req_bank
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_high_set,
  input wire logic i_low_set,
  output logic o_high_flag,
  output logic o_low_flag
);
  logic high_q;
  logic high_d;
  logic low_q;
  logic low_d;

  // sticky: a one-cycle pulse must never be lost
  always_comb
  begin
    high_d = high_q | i_high_set;
    low_d = low_q | i_low_set;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      high_q <= 1'b0;
      low_q <= 1'b0;
    end
    else
    begin
      high_q <= high_d;
      low_q <= low_d;
    end
  end

  assign o_high_flag = high_q;
  assign o_low_flag = low_q;
endmodule : dmct_req_bank

// ===== testbench/dmct_timer_tb_top.sv
// self-checking bench for the dual mode compare timer
`timescale 1ns/1ps
module dmct_timer_tb_top;
  import dmct_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [DMCT_ADDR_W-1:0] addr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] be = 4'h0;
  logic [31:0] rdata;
  logic wait_req;
  logic subclk = 1'b0;
  logic ev = 1'b0;
  logic ev_rise = 1'b1;
  logic hpin;
  logic lpin;
  logic hset;
  logic lset;
  logic hflag;
  logic lflag;
  logic [31:0] exp_q[$];
  int n_mismatch = 0;
  int samples_checked = 0;
  int seed = 32'h70138f61;
  int k;
  logic [7:0] cmpl;
  int c;
  logic [7:0] ticks;

  dmct_timer i_dut (
    .i_core_clk(clk),
    .i_reset(rst),
    .i_avs_address(addr),
    .i_avs_read(rd),
    .i_avs_write(wr),
    .i_avs_writedata(wdata),
    .i_avs_byteenable(be),
    .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_req),
    .i_subclock(subclk),
    .i_event_input_pin(ev),
    .i_event_edge_rising(ev_rise),
    .o_high_toggle_pin(hpin),
    .o_low_toggle_pin(lpin),
    .o_high_request_set(hset),
    .o_low_request_set(lset)
  );

  dmct_req_bank i_bank (
    .i_core_clk(clk),
    .i_reset(rst),
    .i_high_set(hset),
    .i_low_set(lset),
    .o_high_flag(hflag),
    .o_low_flag(lflag)
  );

  initial
  begin
    forever #20 clk = ~clk;
  end

  // subclock toggles every clock, so the sub4 code ticks once per 8 clocks
  always @(posedge clk) subclk <= ~subclk;

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // one avalon transfer; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d,
                     input logic [3:0] b, input logic [7:0] e);
    int n;
    logic [31:0] r;
    r = $random(seed);
    @(posedge clk);
    addr <= {idx, 2'b00};
    rd <= ~w;
    wr <= w;
    wdata <= {r[31:8], d};
    be <= b;
    if (!w)
      exp_q.push_back({24'h0, e});
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wait_req !== 1'b0 && n < 20);
    rd <= 1'b0;
    wr <= 1'b0;
    if (wait_req !== 1'b0)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t bus answer timed out", $time);
      end_sim();
    end
  endtask : bus

  task automatic wreg(input logic [15:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'hf, 8'h00);
  endtask : wreg

  task automatic rreg(input logic [15:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00, 4'hf, e);
  endtask : rreg

  task automatic pins(input logic [1:0] e);
    @(negedge clk);
    check({30'h0, hpin, lpin}, {30'h0, e}, "toggle pins");
  endtask : pins

  // event pulses of random width on the event pin
  task automatic pulses(input int cnt);
    repeat (cnt)
    begin
      k = 2 + {$random(seed)} % 4;
      @(posedge clk);
      ev <= 1'b1;
      repeat (k) @(posedge clk);
      ev <= 1'b0;
      repeat (k) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask : pulses

  // read data are compared in order of issue
  always @(posedge clk)
  begin
    if (rd && wait_req === 1'b0)
    begin
      if (exp_q.size() == 0)
        check(rdata, 32'hffffffff, "unexpected read");
      else
        check(rdata, exp_q.pop_front(), "read data");
    end
  end

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    pins(2'b00);
    check({30'h0, hflag, lflag}, 32'h0, "requests idle");
    rreg(DMCT_IDX_STATUS, 8'h00);
    rreg(DMCT_IDX_CNT_HIGH, 8'h00);
    rreg(DMCT_IDX_CNT_LOW, 8'h00);
    rreg(DMCT_IDX_CMP_HIGH, 8'hff);
    rreg(DMCT_IDX_CMP_LOW, 8'hff);
    rreg(DMCT_IDX_CTRL, 8'h00);
    rreg(DMCT_IDX_CLK_STOP, 8'hff);
    rreg(16'hffbc, 8'h00);
    wreg(DMCT_IDX_CTRL, 8'h88);
    pins(2'b11);
    // 8-bit mode: low half counts event edges and clears on match
    cmpl = 8'h02 + 8'({$random(seed)} % 5);
    wreg(DMCT_IDX_CTRL, 8'h40);
    pins(2'b00);
    wreg(DMCT_IDX_CNT_LOW, 8'h00);
    wreg(DMCT_IDX_CMP_LOW, cmpl);
    bus(1'b1, DMCT_IDX_CMP_HIGH, 8'h12, 4'he, 8'h00);
    rreg(DMCT_IDX_CMP_HIGH, 8'hff);
    rreg(DMCT_IDX_CMP_LOW, cmpl);
    wreg(DMCT_IDX_STATUS, 8'hcd);
    rreg(DMCT_IDX_STATUS, 8'h01);
    pulses(cmpl);
    rreg(DMCT_IDX_CNT_LOW, cmpl);
    pulses(1);
    rreg(DMCT_IDX_CNT_LOW, 8'h00);
    rreg(DMCT_IDX_STATUS, 8'h05);
    pins(2'b01);
    check({30'h0, hflag, lflag}, 32'h1, "low request");
    wreg(DMCT_IDX_STATUS, 8'h01);
    rreg(DMCT_IDX_STATUS, 8'h01);
    // 16-bit mode: load fffe via the temp byte while halted, then run
    wreg(DMCT_IDX_CLK_STOP, 8'hfb);
    wreg(DMCT_IDX_CTRL, 8'h06);
    pins(2'b00);
    wreg(DMCT_IDX_CNT_HIGH, 8'hff);
    wreg(DMCT_IDX_CNT_LOW, 8'hfe);
    wreg(DMCT_IDX_CMP_HIGH, 8'h00);
    wreg(DMCT_IDX_CMP_LOW, 8'h01);
    rreg(DMCT_IDX_CNT_HIGH, 8'hff);
    rreg(DMCT_IDX_CNT_LOW, 8'hfe);
    wreg(DMCT_IDX_STATUS, 8'h20);
    wreg(DMCT_IDX_CLK_STOP, 8'hff);
    for (k = 0; k < 60 && hpin !== 1'b1; k++)
      @(posedge clk);
    pins(2'b10);
    rreg(DMCT_IDX_STATUS, 8'he0);
    check({31'h0, hflag}, 32'h1, "high request");
    // every prescaler code on both halves over a 64-clock run window
    for (c = 4; c < 8; c++)
    begin
      ticks = (c == 4) ? 8'h02 : (c == 5) ? 8'h04 : (c == 6) ? 8'h10 : 8'h08;
      wreg(DMCT_IDX_CLK_STOP, 8'hfb);
      wreg(DMCT_IDX_CTRL, {1'b0, c[2:0], 1'b0, c[2:0]});
      wreg(DMCT_IDX_CNT_HIGH, 8'h00);
      wreg(DMCT_IDX_CNT_LOW, 8'h00);
      wreg(DMCT_IDX_CLK_STOP, 8'hff);
      repeat (61) @(posedge clk);
      wreg(DMCT_IDX_CLK_STOP, 8'hfb);
      rreg(DMCT_IDX_CNT_HIGH, ticks);
      rreg(DMCT_IDX_CNT_LOW, ticks);
    end
    // falling event edges: a rising edge alone must not count
    ev_rise <= 1'b0;
    wreg(DMCT_IDX_CTRL, 8'h40);
    wreg(DMCT_IDX_CNT_LOW, 8'h00);
    wreg(DMCT_IDX_CLK_STOP, 8'hff);
    ev <= 1'b1;
    rreg(DMCT_IDX_CNT_LOW, 8'h00);
    ev <= 1'b0;
    pulses(2);
    rreg(DMCT_IDX_CNT_LOW, 8'h03);
    end_sim();
  end
endmodule : dmct_timer_tb_top
